// ===== hdl/chgadc_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the
//          converter result register block.
// Assumes: Included by bare name after the package.
// Notes:   Offsets are register indices; the byte address is four times.
`ifndef CHGADC_CONSTS_SVH
`define CHGADC_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define CHGADC_IDX_BATCFG 6'h14
`define CHGADC_IDX_CTRL   6'h2E
`define CHGADC_IDX_DIS    6'h30
`define CHGADC_IDX_INPUT_CURRENT   6'h31
`define CHGADC_IDX_BATTERY_CURRENT   6'h33
`define CHGADC_IDX_VBUS   6'h35
`define CHGADC_IDX_SRC1   6'h37
`define CHGADC_IDX_SRC2   6'h39

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CHGADC_BIT_CONVEN 7
`define CHGADC_BIT_BATEN  5
`define CHGADC_DIS_LSB    4
`define CHGADC_RST_DIS    4'h0
`define CHGADC_RST_BIT    1'h0
`define CHGADC_RST_RES    16'h0000

// ****************************************************************
// Magnitude limits: 5000 mA, 8000 mA, 30000 mV
// ****************************************************************
`define CHGADC_INPUT_CURRENT_MAX   16'h1388
`define CHGADC_BATTERY_CURRENT_MAX   16'h1F40
`define CHGADC_VOLT_MAX   16'h7530

// ****************************************************************
// Bus responses
// ****************************************************************
`define CHGADC_RESP_OKAY  2'h0
`define CHGADC_RESP_ERR   2'h2

`endif

// ===== hdl/chgadc_pkg.sv
// Purpose: Types shared by the converter result register block.
// Assumes: Nothing.
// Notes:   Channel order also gives the result slot of the first five.
package chgadc_pkg;
	typedef enum logic [2:0] {
		ch_input_current,
		ch_battery_current,
		ch_bus_voltage,
		ch_source_one,
		ch_source_two,
		ch_plus_line,
		ch_minus_line
	} chgadc_chan_t;

	typedef enum logic [1:0] {
		mode_forward,
		mode_reverse_power,
		mode_high_impedance
	} chgadc_mode_t;

	typedef logic [15:0] chgadc_word_t;
endpackage : chgadc_pkg

// ===== hdl/chgadc_result_reg.sv
// Purpose: One read-only conversion result register.
// Assumes: Load is a one-cycle strobe from the sample path.
// Notes:   Holds its value until the next accepted sample.
`timescale 1ns/1ns
module chgadc_result_reg #(
	parameter int               WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] value,
	output logic      [WIDTH-1:0] value_q
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			value_q <= RESET;
		end else if (load) begin
			value_q <= value;
		end
	end
endmodule : chgadc_result_reg

// ===== hdl/chgadc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the result register block.
// Assumes: One write and one read under way at a time.
// Notes:   Address and data of a write may arrive in either order.
`timescale 1ns/1ns
`include "chgadc_consts.svh"
module chgadc_axil_slave #(
	parameter int ADDR_W = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   wr_en,
	output logic [5:0]             wr_idx,
	output logic [7:0]             wr_data,
	output logic                   wr_lane,
	input  wire logic              wr_err,
	output logic [5:0]             rd_idx,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_err
);
	logic              aw_held_q;
	logic              w_held_q;
	logic [5:0]        aw_idx_q;
	logic [7:0]        w_data_q;
	logic              w_lane_q;
	wire               aw_fire = s_axi_awvalid & s_axi_awready;
	wire               w_fire  = s_axi_wvalid & s_axi_wready;
	wire               ar_fire = s_axi_arvalid & s_axi_arready;
	wire               commit  = aw_held_q & w_held_q & ~s_axi_bvalid;
	wire               aw_held_d = ~commit & (aw_held_q | aw_fire);
	wire               w_held_d  = ~commit & (w_held_q | w_fire);
	wire               rvalid_d  = ar_fire | (s_axi_rvalid & ~s_axi_rready);

	assign wr_en   = commit;
	assign wr_idx  = aw_idx_q;
	assign wr_data = w_data_q;
	assign wr_lane = w_lane_q;
	assign rd_idx  = s_axi_araddr[7:2];

	// ****************************************************************
	// Write channel
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_idx_q      <= 6'h00;
			w_data_q      <= 8'h00;
			w_lane_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CHGADC_RESP_OKAY;
		end else begin
			aw_held_q     <= aw_held_d;
			w_held_q      <= w_held_d;
			s_axi_awready <= ~aw_held_d;
			s_axi_wready  <= ~w_held_d;
			if (aw_fire) begin
				aw_idx_q <= s_axi_awaddr[7:2];
			end
			if (w_fire) begin
				w_data_q <= s_axi_wdata[7:0];
				w_lane_q <= s_axi_wstrb[0];
			end
			if (commit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `CHGADC_RESP_ERR : `CHGADC_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CHGADC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d;
			s_axi_rvalid  <= rvalid_d;
			if (ar_fire) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `CHGADC_RESP_ERR : `CHGADC_RESP_OKAY;
			end
		end
	end
endmodule : chgadc_axil_slave

// ===== hdl/chgadc_regs.sv
// Purpose: Converter result registers and second channel-disable set of a
//          battery charger, reached over AXI4-Lite.
// Assumes: The converter hands over one unsigned magnitude per strobe, with
//          a reversed-flow flag for the input current.
// Notes:   Results saturate at their documented full-scale magnitude.
`timescale 1ns/1ns
`include "chgadc_consts.svh"
module chgadc_regs #(
	parameter int          ADDR_W   = 8,
	parameter logic [15:0] INPUT_CURRENT_MAX = `CHGADC_INPUT_CURRENT_MAX,
	parameter logic [15:0] BATTERY_CURRENT_MAX = `CHGADC_BATTERY_CURRENT_MAX,
	parameter logic [15:0] VOLT_MAX = `CHGADC_VOLT_MAX
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_W-1:0]       s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    watchdog_expired,
	input  wire chgadc_pkg::chgadc_mode_t power_mode,
	input  wire logic                    sample_valid,
	input  wire chgadc_pkg::chgadc_chan_t sample_chan,
	input  wire logic [15:0]             sample_mag,
	input  wire logic                    sample_neg,
	output logic                         conv_enable,
	output logic [6:0]                   chan_request
);
	localparam int NRES = 5;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic chgadc_pkg::chgadc_word_t fn_word(
		input logic [15:0] mag,
		input logic        neg,
		input logic [15:0] lim
	);
		logic [15:0] m;
		m = (mag > lim) ? lim : mag;
		fn_word = neg ? (~m + 16'h0001) : m;
	endfunction : fn_word

	function automatic logic fn_mapped(input logic [5:0] idx);
		fn_mapped = (idx == `CHGADC_IDX_BATCFG) || (idx == `CHGADC_IDX_CTRL)
			|| (idx == `CHGADC_IDX_DIS) || (idx == `CHGADC_IDX_INPUT_CURRENT)
			|| (idx == `CHGADC_IDX_BATTERY_CURRENT) || (idx == `CHGADC_IDX_VBUS)
			|| (idx == `CHGADC_IDX_SRC1) || (idx == `CHGADC_IDX_SRC2);
	endfunction : fn_mapped

	// ****************************************************************
	// Bus front end
	// ****************************************************************
	logic        wr_en;
	logic [5:0]  wr_idx;
	logic [7:0]  wr_data;
	logic        wr_lane;
	logic [5:0]  rd_idx;
	logic [31:0] rd_data;

	chgadc_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_idx        (wr_idx),
		.wr_data       (wr_data),
		.wr_lane       (wr_lane),
		.wr_err        (~fn_mapped(wr_idx)),
		.rd_idx        (rd_idx),
		.rd_data       (rd_data),
		.rd_err        (~fn_mapped(rd_idx))
	);

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [3:0] dis_q;
	logic       conv_en_q;
	logic       bat_en_q;
	wire        wr_ok   = wr_en & wr_lane;
	wire        wr_dis  = wr_ok & (wr_idx == `CHGADC_IDX_DIS);
	wire        wr_ctrl = wr_ok & (wr_idx == `CHGADC_IDX_CTRL);
	wire        wr_bat  = wr_ok & (wr_idx == `CHGADC_IDX_BATCFG);

	// Only the top nibble is stored, so the reserved low bits cannot hold.
	wire [3:0]  dis_d = wr_dis ? wr_data[7:`CHGADC_DIS_LSB] : dis_q;

	// Watchdog expiry wins over a write landing in the same cycle, since it
	// stands for a lost host and must leave the converter off.
	wire        conv_en_d = watchdog_expired ? 1'b0
		: (wr_ctrl ? wr_data[`CHGADC_BIT_CONVEN] : conv_en_q);
	wire        bat_en_d = wr_bat ? wr_data[`CHGADC_BIT_BATEN] : bat_en_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dis_q     <= `CHGADC_RST_DIS;
			conv_en_q <= `CHGADC_RST_BIT;
			bat_en_q  <= `CHGADC_RST_BIT;
		end else begin
			dis_q     <= dis_d;
			conv_en_q <= conv_en_d;
			bat_en_q  <= bat_en_d;
		end
	end

	// ****************************************************************
	// Channel requests
	// ****************************************************************
	// Bit order follows the channel type: dis_q[3..0] are plus line,
	// minus line, source two and source one, while request bits 6..3 are
	// minus line, plus line, source two and source one.
	// The two line bits therefore cross over between the two orders.
	wire [6:0] chan_on = {7{conv_en_q}} & {~dis_q[2], ~dis_q[3], ~dis_q[1],
		~dis_q[0], 3'b111};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chan_request <= 7'h00;
			conv_enable  <= 1'b0;
		end else begin
			chan_request <= chan_on;
			conv_enable  <= conv_en_q;
		end
	end

	// ****************************************************************
	// Sample capture
	// ****************************************************************
	// A sample for a skipped channel is dropped, so a late strobe from the
	// converter cannot overwrite a result that software stopped refreshing.
	wire accept = sample_valid & chan_on[sample_chan];

	wire bat_fwd    = (power_mode == chgadc_pkg::mode_forward);
	wire bat_report = bat_fwd | bat_en_q;

	chgadc_pkg::chgadc_word_t res_d [NRES];
	chgadc_pkg::chgadc_word_t res_q [NRES];

	assign res_d[0] = fn_word(sample_mag, sample_neg, INPUT_CURRENT_MAX);
	// Battery direction follows the power mode: charging only in forward.
	assign res_d[1] = bat_report ? fn_word(sample_mag, ~bat_fwd, BATTERY_CURRENT_MAX)
		: `CHGADC_RST_RES;
	assign res_d[2] = fn_word(sample_mag, 1'b0, VOLT_MAX);
	assign res_d[3] = fn_word(sample_mag, 1'b0, VOLT_MAX);
	assign res_d[4] = fn_word(sample_mag, 1'b0, VOLT_MAX);

	for (genvar i = 0; i < NRES; i++) begin : g_res
		chgadc_result_reg #(
			.WIDTH (16),
			.RESET (`CHGADC_RST_RES)
		) u_res (
			.ref_clk (ref_clk),
			.rst     (rst),
			.load    (accept && (int'(sample_chan) == i)),
			.value   (res_d[i]),
			.value_q (res_q[i])
		);
	end

	// ****************************************************************
	// Read decode
	// ****************************************************************
	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_idx == `CHGADC_IDX_DIS) begin
			rd_data[7:`CHGADC_DIS_LSB] = dis_q;
		end else if (rd_idx == `CHGADC_IDX_CTRL) begin
			rd_data[`CHGADC_BIT_CONVEN] = conv_en_q;
		end else if (rd_idx == `CHGADC_IDX_BATCFG) begin
			rd_data[`CHGADC_BIT_BATEN] = bat_en_q;
		end else if (rd_idx == `CHGADC_IDX_INPUT_CURRENT) begin
			rd_data[15:0] = res_q[0];
		end else if (rd_idx == `CHGADC_IDX_BATTERY_CURRENT) begin
			rd_data[15:0] = res_q[1];
		end else if (rd_idx == `CHGADC_IDX_VBUS) begin
			rd_data[15:0] = res_q[2];
		end else if (rd_idx == `CHGADC_IDX_SRC1) begin
			rd_data[15:0] = res_q[3];
		end else if (rd_idx == `CHGADC_IDX_SRC2) begin
			rd_data[15:0] = res_q[4];
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	wire ld_input_current = accept && (sample_chan == chgadc_pkg::ch_input_current);
	wire ld_battery_current = accept && (sample_chan == chgadc_pkg::ch_battery_current);
	wire ar_hit_dis = s_axi_arvalid && s_axi_arready
		&& (s_axi_araddr[7:2] == `CHGADC_IDX_DIS);

	a_reset_clears: assert property (@(posedge ref_clk)
		rst |=> (dis_q == 4'h0) && !conv_en_q && (res_q[0] == 16'h0000)
			&& (res_q[2] == 16'h0000))
		else $error("reset left a control bit or result set");

	a_disable_skips: assert property (@(posedge ref_clk)
		disable iff (rst)
		conv_en_q && dis_q[3] |=> !chan_request[5])
		else $error("plus line requested while skipped");

	a_minus_skips: assert property (@(posedge ref_clk)
		disable iff (rst)
		conv_en_q && dis_q[2] |=> !chan_request[6])
		else $error("minus line requested while skipped");

	a_enable_copy: assert property (@(posedge ref_clk)
		disable iff (rst)
		conv_enable == $past(conv_en_q))
		else $error("converter enable output does not follow the bit");

	a_global_gate: assert property (@(posedge ref_clk)
		disable iff (rst)
		watchdog_expired |=> !conv_en_q ##1 (chan_request == 7'h00))
		else $error("watchdog did not stop conversions");

	a_rsvd_nibble: assert property (@(posedge ref_clk)
		disable iff (rst)
		ar_hit_dis |=> (s_axi_rdata[3:0] == 4'h0)
			&& (s_axi_rdata[31:8] == 24'h000000))
		else $error("reserved disable bits read nonzero");

	a_input_current_sign: assert property (@(posedge ref_clk)
		disable iff (rst)
		ld_input_current && (sample_mag != 16'h0000)
			|=> (res_q[0][15] == $past(sample_neg)))
		else $error("input current sign does not follow flow");

	a_input_current_range: assert property (@(posedge ref_clk)
		disable iff (rst)
		($signed(res_q[0]) <= 5000) && ($signed(res_q[0]) >= -5000))
		else $error("input current beyond 5000 mA");

	a_battery_current_charge: assert property (@(posedge ref_clk)
		disable iff (rst)
		ld_battery_current && bat_fwd |=> !res_q[1][15]
			&& (res_q[1] == (($past(sample_mag) > 16'h1F40) ? 16'h1F40
				: $past(sample_mag))))
		else $error("charging current wrong or signed");

	a_battery_current_gated: assert property (@(posedge ref_clk)
		disable iff (rst)
		ld_battery_current && !bat_fwd && !bat_en_q |=> (res_q[1] == 16'h0000))
		else $error("discharge shown without measure enable");

	a_vbus_range: assert property (@(posedge ref_clk)
		disable iff (rst)
		res_q[2] <= 16'h7530)
		else $error("bus voltage beyond 30000 mV");
endmodule : chgadc_regs

// ===== sim/tb_chgadc_regs.sv
// Purpose: Self-checking bench for the converter result register block.
// Assumes: Result words come back in the low 16 bits of read data.
// Notes:   Each scenario is its own task; bus cycles go through shared tasks.
`timescale 1ns/1ns
`include "chgadc_consts.svh"
module tb_chgadc_regs;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic                     ref_clk, rst;
	logic [7:0]               s_axi_awaddr, s_axi_araddr;
	logic                     s_axi_awvalid, s_axi_awready;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic                     s_axi_wvalid, s_axi_wready;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic                     s_axi_bvalid, s_axi_bready;
	logic                     s_axi_arvalid, s_axi_arready;
	logic                     s_axi_rvalid, s_axi_rready;
	logic                     watchdog_expired, sample_valid, sample_neg;
	chgadc_pkg::chgadc_mode_t power_mode;
	chgadc_pkg::chgadc_chan_t sample_chan;
	logic [15:0]              sample_mag;
	logic                     conv_enable;
	logic [6:0]               chan_request;
	int                       miscompares, cmp_count, cyc;
	logic [1:0]               resp;

	chgadc_regs i_chgadc_regs (.ref_clk(ref_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .watchdog_expired(watchdog_expired),
		.power_mode(power_mode), .sample_valid(sample_valid),
		.sample_chan(sample_chan), .sample_mag(sample_mag),
		.sample_neg(sample_neg), .conv_enable(conv_enable),
		.chan_request(chan_request));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk

	// Address and data are offered together; either may be taken first.
	task automatic wr(input logic [5:0] idx, input logic [7:0] d,
			output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr  <= {idx, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_wstrb   <= 4'hF;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [5:0] idx, output logic [31:0] d,
			output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr  <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd

	task automatic rd_chk(input string what, input logic [5:0] idx,
			input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		chk(what, exp, d);
		chk({what, " resp"}, {30'h0, er}, {30'h0, r});
	endtask : rd_chk

	task automatic smp(input chgadc_pkg::chgadc_chan_t ch,
			input logic [15:0] mag, input logic neg);
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		sample_chan  <= ch;
		sample_mag   <= mag;
		sample_neg   <= neg;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
	endtask : smp

	// Lets the enable copy and the request vector settle, then looks.
	task automatic req_chk(input logic [6:0] exp);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("chan_request", {25'h0, exp}, {25'h0, chan_request});
	endtask : req_chk

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_values;
		rd_chk("input_current", `CHGADC_IDX_INPUT_CURRENT, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("battery_current", `CHGADC_IDX_BATTERY_CURRENT, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("vbus", `CHGADC_IDX_VBUS, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("src1", `CHGADC_IDX_SRC1, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("src2", `CHGADC_IDX_SRC2, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("dis", `CHGADC_IDX_DIS, 32'h0, `CHGADC_RESP_OKAY);
		chk("conv_enable", 32'h0, {31'h0, conv_enable});
		req_chk(7'h00);
	endtask : t_reset_values

	task automatic t_disable_bits;
		wr(`CHGADC_IDX_DIS, 8'hFF, resp);
		rd_chk("dis ff", `CHGADC_IDX_DIS, 32'hF0, `CHGADC_RESP_OKAY);
		req_chk(7'h00);
		wr(`CHGADC_IDX_CTRL, 8'h80, resp);
		req_chk(7'h07);
		chk("conv_enable on", 32'h1, {31'h0, conv_enable});
		wr(`CHGADC_IDX_DIS, 8'h80, resp);
		chk("dis resp", 32'h0, {30'h0, resp});
		req_chk(7'h5F);
		wr(`CHGADC_IDX_DIS, 8'h40, resp);
		req_chk(7'h3F);
		wr(`CHGADC_IDX_DIS, 8'h10, resp);
		req_chk(7'h77);
		smp(chgadc_pkg::ch_source_one, 16'h0309, 1'b0);
		rd_chk("src1 skip", `CHGADC_IDX_SRC1, 32'h0, `CHGADC_RESP_OKAY);
		wr(`CHGADC_IDX_DIS, 8'h00, resp);
		req_chk(7'h7F);
	endtask : t_disable_bits

	task automatic t_results;
		smp(chgadc_pkg::ch_input_current, 16'h0064, 1'b1);
		rd_chk("input_current neg", `CHGADC_IDX_INPUT_CURRENT, 32'hFF9C, `CHGADC_RESP_OKAY);
		smp(chgadc_pkg::ch_input_current, 16'h1770, 1'b0);
		rd_chk("input_current sat", `CHGADC_IDX_INPUT_CURRENT, 32'h1388, `CHGADC_RESP_OKAY);
		wr(`CHGADC_IDX_INPUT_CURRENT, 8'h55, resp);
		rd_chk("input_current ro", `CHGADC_IDX_INPUT_CURRENT, 32'h1388, `CHGADC_RESP_OKAY);
		smp(chgadc_pkg::ch_bus_voltage, 16'h9C40, 1'b0);
		smp(chgadc_pkg::ch_source_one, 16'h04D2, 1'b0);
		smp(chgadc_pkg::ch_source_two, 16'h7530, 1'b0);
		rd_chk("vbus", `CHGADC_IDX_VBUS, 32'h7530, `CHGADC_RESP_OKAY);
		rd_chk("src1", `CHGADC_IDX_SRC1, 32'h04D2, `CHGADC_RESP_OKAY);
		rd_chk("src2", `CHGADC_IDX_SRC2, 32'h7530, `CHGADC_RESP_OKAY);
	endtask : t_results

	task automatic t_battery;
		smp(chgadc_pkg::ch_battery_current, 16'h01F4, 1'b0);
		rd_chk("battery_current fwd", `CHGADC_IDX_BATTERY_CURRENT, 32'h01F4, `CHGADC_RESP_OKAY);
		power_mode <= chgadc_pkg::mode_reverse_power;
		smp(chgadc_pkg::ch_battery_current, 16'h01F4, 1'b0);
		rd_chk("battery_current off", `CHGADC_IDX_BATTERY_CURRENT, 32'h0, `CHGADC_RESP_OKAY);
		wr(`CHGADC_IDX_BATCFG, 8'h20, resp);
		smp(chgadc_pkg::ch_battery_current, 16'h01F4, 1'b0);
		rd_chk("battery_current rev", `CHGADC_IDX_BATTERY_CURRENT, 32'hFE0C, `CHGADC_RESP_OKAY);
		power_mode <= chgadc_pkg::mode_high_impedance;
		smp(chgadc_pkg::ch_battery_current, 16'h2328, 1'b0);
		rd_chk("battery_current hiz", `CHGADC_IDX_BATTERY_CURRENT, 32'hE0C0, `CHGADC_RESP_OKAY);
		power_mode <= chgadc_pkg::mode_forward;
	endtask : t_battery

	task automatic t_enable_clear;
		watchdog_expired <= 1'b1;
		@(posedge ref_clk);
		watchdog_expired <= 1'b0;
		rd_chk("ctrl wdog", `CHGADC_IDX_CTRL, 32'h0, `CHGADC_RESP_OKAY);
		req_chk(7'h00);
		smp(chgadc_pkg::ch_input_current, 16'h0001, 1'b0);
		rd_chk("input_current idle", `CHGADC_IDX_INPUT_CURRENT, 32'h1388, `CHGADC_RESP_OKAY);
		wr(6'h01, 8'h11, resp);
		chk("unmapped wr", {30'h0, `CHGADC_RESP_ERR}, {30'h0, resp});
		rd_chk("unmapped", 6'h01, 32'h0, `CHGADC_RESP_ERR);
		wr(`CHGADC_IDX_DIS, 8'hC0, resp);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk("dis rst", `CHGADC_IDX_DIS, 32'h0, `CHGADC_RESP_OKAY);
		rd_chk("input_current rst", `CHGADC_IDX_INPUT_CURRENT, 32'h0, `CHGADC_RESP_OKAY);
	endtask : t_enable_clear

	// ****************************************************************
	// Main sequence and hang guard
	// ****************************************************************
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
		{s_axi_rready, watchdog_expired, sample_valid} = '0;
		{sample_mag, sample_neg} = '0;
		power_mode  = chgadc_pkg::mode_forward;
		sample_chan = chgadc_pkg::ch_input_current;
		miscompares = 0;
		cmp_count   = 0;
		cyc         = 0;
		rst         = 1'b1;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset_values();
		t_disable_bits();
		t_results();
		t_battery();
		t_enable_clear();
		give_verdict();
	end
endmodule : tb_chgadc_regs
